// ### include/uhlc_regs.svh
// Register offsets, field positions, reset values and timing counts of the list command/status block
`ifndef UHLC_REGS_SVH
`define UHLC_REGS_SVH

`define UHLC_OFS_CTRL      8'h04
`define UHLC_OFS_CMD       8'h08
`define UHLC_OFS_INT       8'h0C
`define UHLC_RESET_VAL     32'h0000_0000
`define UHLC_ZERO32        32'h0000_0000

`define UHLC_CT_RATIO_HI   1
`define UHLC_CT_RATIO_LO   0
`define UHLC_CT_PERIODIC   2
`define UHLC_CT_ISO        3
`define UHLC_CT_CTRL       4
`define UHLC_CT_BULK       5

`define UHLC_CS_SRST       0
`define UHLC_CS_CTRL_PEND  1
`define UHLC_CS_BULK_PEND  2
`define UHLC_CS_OWNER_REQ  3
`define UHLC_CS_TALLY_LO   16
`define UHLC_CS_TALLY_HI   17

`define UHLC_IS_OVERRUN    0
`define UHLC_IS_LOW_HI     3
`define UHLC_IS_FATAL      4
`define UHLC_IS_FNO        5
`define UHLC_IS_ROOT       6
`define UHLC_IS_OWNER      30
`define UHLC_FRAME_MSB     15

`define UHLC_CLK_NS        5
`define UHLC_SRST_NS       80
`define UHLC_SRST_CYC      ((`UHLC_SRST_NS + `UHLC_CLK_NS - 1) / `UHLC_CLK_NS)

`endif

// ### include/uhlc_pkg.sv
// Types shared by the list command/status block
package uhlc_pkg;
    typedef enum logic [0:0] {
        UHLC_RST_IDLE = 1'b0,
        UHLC_RST_BUSY = 1'b1
    } uhlc_rst_state_t;
endpackage

// ### rtl/uhlc_list_cmd_status.sv
// List enables, command/status and event status logic of the USB host controller
//
// Contract
// - Control list walked only while its enable bit is one, skipped otherwise.
// - Isochronous descriptors skipped when iso enable is zero; interrupt ones still served.
// - Periodic enable sampled at frame start; zero means no periodic work that frame.
// - Serve ratio field plus one control endpoints per bulk endpoint.
// - Two-bit overrun tally increments each time overrun status becomes set, wraps.
// - Software writing one sets handover request and raises the handover event.
// - Hardware never clears the handover request; software does.
// - Bulk pending set by software or engine, cleared when bulk head processing starts.
// - Control pending set by software or engine, cleared when control head processing starts.
// - Writing one to soft reset starts reset; hardware clears it when done.
// - Handover event set whenever handover request is set.
// - Root change event set whenever root hub or port state content changes.
// - Frame overflow event set whenever frame count bit 15 toggles.
// - Fatal fault event reads zero and ignores writes.
// - Reserved bits of command/status and event status read zero.
// - Command/status and event status are all zero after reset.
`timescale 1ns/1ps
`include "uhlc_regs.svh"

module uhlc_list_cmd_status (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Register port
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    output logic      [31:0] regRdData,
    output logic             regRdValid,
    // List engine
    input  wire logic        frameStart,
    input  wire logic        isoDescSeen,
    input  wire logic        ctrlEpDone,
    input  wire logic        bulkEpDone,
    input  wire logic        ctrlHeadStart,
    input  wire logic        bulkHeadStart,
    input  wire logic        engCtrlPendSet,
    input  wire logic        engBulkPendSet,
    output logic             ctrlListGo,
    output logic             bulkListGo,
    output logic             periodicFrameGo,
    output logic             isoDescServe,
    output logic             pickBulk,
    output logic             ctrlPending,
    output logic             bulkPending,
    // Soft reset
    output logic             softResetActive,
    // Event sources
    input  wire logic [3:0]  lowEventIn,
    input  wire logic [15:0] frameCount,
    input  wire logic [31:0] rootHubState,
    input  wire logic [63:0] rootPortState,
    // Handover
    output logic             ownerHandoverReq
);

    logic                      wrCtl;
    logic                      wrCmd;
    logic                      wrInt;
    logic [5:0]                ctrlReg_q,     ctrlReg_d;
    logic                      softRst_q,     softRst_d;
    logic                      ctrlPend_q,    ctrlPend_d;
    logic                      bulkPend_q,    bulkPend_d;
    logic                      ownerReq_q,    ownerReq_d;
    logic [1:0]                tally_q,       tally_d;
    logic                      ownerEvt_q,    ownerEvt_d;
    logic                      rootEvt_q,     rootEvt_d;
    logic                      fnoEvt_q,      fnoEvt_d;
    logic [3:0]                lowEvt_q,      lowEvt_d;
    logic                      fnoMsb_q,      fnoMsb_d;
    logic [31:0]               hubPrev_q,     hubPrev_d;
    logic [63:0]               portPrev_q,    portPrev_d;
    logic                      primed_q,      primed_d;
    logic                      perGo_q,       perGo_d;
    logic [2:0]                ctrlServed_q,  ctrlServed_d;
    uhlc_pkg::uhlc_rst_state_t rstState_q,    rstState_d;
    logic [4:0]                rstCnt_q,      rstCnt_d;
    logic [31:0]               rdData_q,      rdData_d;
    logic                      rdValid_q,     rdValid_d;
    logic [31:0]               ctrlView;
    logic [31:0]               cmdView;
    logic [31:0]               intView;
    logic                      rstBusy;
    logic                      rootChange;
    logic                      overrunRise;

    assign wrCtl   = regWrEn && (regAddr == `UHLC_OFS_CTRL);
    assign wrCmd   = regWrEn && (regAddr == `UHLC_OFS_CMD);
    assign wrInt   = regWrEn && (regAddr == `UHLC_OFS_INT);
    assign rstBusy = (rstState_q == uhlc_pkg::UHLC_RST_BUSY);

    // Reserved bits and the fatal fault event are simply never stored
    assign ctrlView = {26'h000_0000, ctrlReg_q};
    assign cmdView  = {14'h0000, tally_q, 12'h000, ownerReq_q, bulkPend_q, ctrlPend_q, softRst_q};
    assign intView  = {1'b0, ownerEvt_q, 23'h00_0000, rootEvt_q, fnoEvt_q, 1'b0, lowEvt_q};

    // First cycle after reset only captures state, so reset values are not seen as a change
    assign rootChange  = primed_q && ((rootHubState != hubPrev_q) || (rootPortState != portPrev_q));
    assign overrunRise = lowEventIn[`UHLC_IS_OVERRUN] && !lowEvt_q[`UHLC_IS_OVERRUN];

    // Register file, soft reset sequencer and event capture
    always_comb begin
        ctrlReg_d  = ctrlReg_q;
        softRst_d  = softRst_q;
        ctrlPend_d = ctrlPend_q;
        bulkPend_d = bulkPend_q;
        ownerReq_d = ownerReq_q;
        tally_d    = tally_q;
        ownerEvt_d = ownerEvt_q;
        rootEvt_d  = rootEvt_q;
        fnoEvt_d   = fnoEvt_q;
        lowEvt_d   = lowEvt_q;
        rstState_d = rstState_q;
        rstCnt_d   = rstCnt_q;
        if (wrCtl) begin
            ctrlReg_d = regWrData[5:0];
        end
        // Hardware set wins over a clear in the same cycle
        ctrlPend_d = (ctrlPend_q && !ctrlHeadStart) || engCtrlPendSet
                     || (wrCmd && regWrData[`UHLC_CS_CTRL_PEND]);
        bulkPend_d = (bulkPend_q && !bulkHeadStart) || engBulkPendSet
                     || (wrCmd && regWrData[`UHLC_CS_BULK_PEND]);
        // Handover request is withdrawn only by software clearing its event
        ownerReq_d = (ownerReq_q && !(wrInt && regWrData[`UHLC_IS_OWNER]))
                     || (wrCmd && regWrData[`UHLC_CS_OWNER_REQ]);
        ownerEvt_d = (ownerEvt_q && !(wrInt && regWrData[`UHLC_IS_OWNER]))
                     || (wrCmd && regWrData[`UHLC_CS_OWNER_REQ]);
        rootEvt_d  = (rootEvt_q && !(wrInt && regWrData[`UHLC_IS_ROOT])) || rootChange;
        fnoEvt_d   = (fnoEvt_q && !(wrInt && regWrData[`UHLC_IS_FNO]))
                     || (frameCount[`UHLC_FRAME_MSB] != fnoMsb_q);
        lowEvt_d   = (lowEvt_q & ~(wrInt ? regWrData[`UHLC_IS_LOW_HI:0] : 4'h0)) | lowEventIn;
        if (overrunRise) begin
            tally_d = tally_q + 2'h1;
        end
        case (rstState_q)
            uhlc_pkg::UHLC_RST_IDLE: begin
                if (wrCmd && regWrData[`UHLC_CS_SRST]) begin
                    softRst_d  = 1'b1;
                    rstState_d = uhlc_pkg::UHLC_RST_BUSY;
                    rstCnt_d   = 5'h00;
                end
            end
            uhlc_pkg::UHLC_RST_BUSY: begin
                // Reset dominates all other updates except the handover request and event while it runs
                ctrlReg_d  = 6'h00;
                ctrlPend_d = 1'b0;
                bulkPend_d = 1'b0;
                tally_d    = 2'h0;
                rootEvt_d  = 1'b0;
                fnoEvt_d   = 1'b0;
                lowEvt_d   = 4'h0;
                rstCnt_d   = rstCnt_q + 5'h01;
                if (rstCnt_q == 5'(`UHLC_SRST_CYC - 1)) begin
                    softRst_d  = 1'b0;
                    rstState_d = uhlc_pkg::UHLC_RST_IDLE;
                end
            end
            default: begin
                rstState_d = uhlc_pkg::UHLC_RST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrlReg_q  <= 6'h00;
            softRst_q  <= 1'b0;
            ctrlPend_q <= 1'b0;
            bulkPend_q <= 1'b0;
            ownerReq_q <= 1'b0;
            tally_q    <= 2'h0;
            ownerEvt_q <= 1'b0;
            rootEvt_q  <= 1'b0;
            fnoEvt_q   <= 1'b0;
            lowEvt_q   <= 4'h0;
            rstState_q <= uhlc_pkg::UHLC_RST_IDLE;
            rstCnt_q   <= 5'h00;
        end else begin
            ctrlReg_q  <= ctrlReg_d;
            softRst_q  <= softRst_d;
            ctrlPend_q <= ctrlPend_d;
            bulkPend_q <= bulkPend_d;
            ownerReq_q <= ownerReq_d;
            tally_q    <= tally_d;
            ownerEvt_q <= ownerEvt_d;
            rootEvt_q  <= rootEvt_d;
            fnoEvt_q   <= fnoEvt_d;
            lowEvt_q   <= lowEvt_d;
            rstState_q <= rstState_d;
            rstCnt_q   <= rstCnt_d;
        end
    end

    // Change detectors, list scheduling and read port
    always_comb begin
        fnoMsb_d     = frameCount[`UHLC_FRAME_MSB];
        hubPrev_d    = rootHubState;
        portPrev_d   = rootPortState;
        primed_d     = 1'b1;
        perGo_d      = perGo_q;
        ctrlServed_d = ctrlServed_q;
        rdValid_d    = regRdEn;
        rdData_d     = rdData_q;
        if (frameStart) begin
            perGo_d = ctrlReg_q[`UHLC_CT_PERIODIC] && !rstBusy;
        end
        if (bulkEpDone) begin
            ctrlServed_d = 3'h0;
        end else if (ctrlEpDone && (ctrlServed_q != 3'h7)) begin
            ctrlServed_d = ctrlServed_q + 3'h1;
        end
        if (regRdEn) begin
            case (regAddr)
                `UHLC_OFS_CTRL: rdData_d = ctrlView;
                `UHLC_OFS_CMD:  rdData_d = cmdView;
                `UHLC_OFS_INT:  rdData_d = intView;
                default:        rdData_d = `UHLC_ZERO32;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fnoMsb_q     <= 1'b0;
            hubPrev_q    <= 32'h0000_0000;
            portPrev_q   <= 64'h0000_0000_0000_0000;
            primed_q     <= 1'b0;
            perGo_q      <= 1'b0;
            ctrlServed_q <= 3'h0;
            rdValid_q    <= 1'b0;
            rdData_q     <= `UHLC_ZERO32;
        end else begin
            fnoMsb_q     <= fnoMsb_d;
            hubPrev_q    <= hubPrev_d;
            portPrev_q   <= portPrev_d;
            primed_q     <= primed_d;
            perGo_q      <= perGo_d;
            ctrlServed_q <= ctrlServed_d;
            rdValid_q    <= rdValid_d;
            rdData_q     <= rdData_d;
        end
    end

    assign ctrlListGo       = ctrlReg_q[`UHLC_CT_CTRL] && !rstBusy;
    assign bulkListGo       = ctrlReg_q[`UHLC_CT_BULK] && !rstBusy;
    assign periodicFrameGo  = perGo_q;
    assign isoDescServe     = isoDescSeen && perGo_q && ctrlReg_q[`UHLC_CT_ISO];
    // Bulk gets its turn once ratio plus one control endpoints were served
    assign pickBulk         = ctrlServed_q > {1'b0, ctrlReg_q[`UHLC_CT_RATIO_HI:`UHLC_CT_RATIO_LO]};
    assign ctrlPending      = ctrlPend_q;
    assign bulkPending      = bulkPend_q;
    assign softResetActive  = softRst_q;
    assign ownerHandoverReq = ownerReq_q;
    assign regRdData        = rdData_q;
    assign regRdValid       = rdValid_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_ctrl_gate;
        !ctrlReg_q[`UHLC_CT_CTRL] |-> !ctrlListGo;
    endproperty
    a_ctrl_gate: assert property (p_ctrl_gate) else $error("control list walked while disabled");

    property p_iso_skip;
        isoDescSeen && !ctrlReg_q[`UHLC_CT_ISO] |-> !isoDescServe;
    endproperty
    a_iso_skip: assert property (p_iso_skip) else $error("iso descriptor served while iso disabled");

    property p_per_frame;
        frameStart && !ctrlReg_q[`UHLC_CT_PERIODIC] |=> !periodicFrameGo;
    endproperty
    a_per_frame: assert property (p_per_frame) else $error("periodic work in disabled frame");

    property p_ratio;
        $rose(pickBulk) && $stable(ctrlReg_q[1:0]) |-> ctrlServed_q == 3'({1'b0, ctrlReg_q[1:0]} + 3'h1);
    endproperty
    a_ratio: assert property (p_ratio) else $error("bulk turn at wrong control count");

    property p_tally;
        overrunRise && !rstBusy |=> tally_q == $past(tally_q) + 2'h1;
    endproperty
    a_tally: assert property (p_tally) else $error("overrun tally did not step");

    property p_owner_set;
        wrCmd && regWrData[`UHLC_CS_OWNER_REQ] |=> ownerReq_q && ownerEvt_q;
    endproperty
    a_owner_set: assert property (p_owner_set) else $error("handover request not taken");

    property p_owner_hold;
        ownerReq_q && !(wrInt && regWrData[`UHLC_IS_OWNER]) |=> ownerReq_q;
    endproperty
    a_owner_hold: assert property (p_owner_hold) else $error("handover request dropped by hardware");

    property p_bulk_clr;
        bulkHeadStart && !engBulkPendSet && !wrCmd |=> !bulkPending;
    endproperty
    a_bulk_clr: assert property (p_bulk_clr) else $error("bulk pending not cleared");

    property p_ctrl_clr;
        ctrlHeadStart && !engCtrlPendSet && !wrCmd |=> !ctrlPending;
    endproperty
    a_ctrl_clr: assert property (p_ctrl_clr) else $error("control pending not cleared");

    property p_srst;
        $rose(softRst_q) |-> softRst_q [*8] ##[1:12] !softRst_q;
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset length wrong");

    property p_owner_evt;
        ownerReq_q |-> ownerEvt_q;
    endproperty
    a_owner_evt: assert property (p_owner_evt) else $error("handover event missing");

    property p_fno;
        $changed(frameCount[`UHLC_FRAME_MSB]) && !rstBusy |=> fnoEvt_q;
    endproperty
    a_fno: assert property (p_fno) else $error("frame overflow not flagged");

    property p_reserved;
        regRdEn && regAddr == `UHLC_OFS_INT |=> regRdData[`UHLC_IS_FATAL] == 1'b0 && regRdData[29:7] == 23'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved event bits nonzero");

    c_srst:  cover property ($fell(softRst_q));
    c_owner: cover property (ownerEvt_q && wrInt && regWrData[`UHLC_IS_OWNER]);
    c_bulk:  cover property ($rose(pickBulk) && ctrlReg_q[1:0] == 2'h3);
    c_tally: cover property (overrunRise && tally_q == 2'h3);

endmodule // uhlc_list_cmd_status

// ### tb/uhlc_root_port_model.sv
// Behavioural root hub ports and frame counter feeding the event sources
`timescale 1ns/1ps

module uhlc_root_port_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Commands from the bench
    input  wire logic        flipFrame,
    input  wire logic        touchPort,
    // State seen by the block
    output logic      [15:0] frameCount,
    output logic      [31:0] rootHubState,
    output logic      [63:0] rootPortState
);
    // Frame count jumps by half its range plus one so bit 15 flips without a 32k-cycle wait
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            frameCount    <= 16'h0000;
            rootHubState  <= 32'h0000_0000;
            rootPortState <= 64'h0000_0000_0000_0000;
        end else begin
            if (flipFrame) frameCount <= frameCount + 16'h8001;
            if (touchPort) rootPortState <= rootPortState ^ 64'h0000_0001_0000_0000;
            // Hub word moves on every second touch so both change sources are exercised
            if (touchPort) rootHubState <= rootHubState ^ {31'h0000_0000, rootPortState[32]};
        end
    end
endmodule // uhlc_root_port_model

// ### tb/tb_top.sv
// Self-checking bench for the list command/status block
`timescale 1ns/1ps

module tb_top;
    logic        clk;
    logic        reset_n;
    logic        regWrEn;
    logic        regRdEn;
    logic [7:0]  regAddr;
    logic [31:0] regWrData;
    logic [31:0] regRdData;
    logic        regRdValid;
    logic        isoDescSeen;
    logic [9:0]  eng;
    logic        ctrlListGo;
    logic        bulkListGo;
    logic        periodicFrameGo;
    logic        isoDescServe;
    logic        pickBulk;
    logic        ctrlPending;
    logic        bulkPending;
    logic        softResetActive;
    logic        ownerHandoverReq;
    logic [15:0] frameCount;
    logic [31:0] rootHubState;
    logic [63:0] rootPortState;
    int          mismatches;
    int          compares;
    int          n;
    // Columns: write offset, write data, read offset, expected read
    localparam logic [31:0] ROWS [0:5][0:3] = '{
        '{32'h04, 32'h0000_003F, 32'h04, 32'h0000_003F},
        '{32'h04, 32'hFFFF_FFFF, 32'h04, 32'h0000_003F},
        '{32'h08, 32'h0000_0006, 32'h08, 32'h0000_0006},
        '{32'h08, 32'h0000_0000, 32'h08, 32'h0000_0006},
        '{32'h0C, 32'hBFFF_FF90, 32'h0C, 32'h0000_0000},
        '{32'h10, 32'hFFFF_FFFF, 32'h10, 32'h0000_0000}};

    uhlc_list_cmd_status i_dut (.clk(clk), .reset_n(reset_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
        .frameStart(eng[0]), .isoDescSeen(isoDescSeen), .ctrlEpDone(eng[1]), .bulkEpDone(eng[2]),
        .ctrlHeadStart(eng[3]), .bulkHeadStart(eng[4]), .engCtrlPendSet(eng[5]), .engBulkPendSet(eng[6]),
        .ctrlListGo(ctrlListGo), .bulkListGo(bulkListGo), .periodicFrameGo(periodicFrameGo),
        .isoDescServe(isoDescServe), .pickBulk(pickBulk), .ctrlPending(ctrlPending),
        .bulkPending(bulkPending), .softResetActive(softResetActive), .lowEventIn({3'b000, eng[7]}),
        .frameCount(frameCount), .rootHubState(rootHubState), .rootPortState(rootPortState),
        .ownerHandoverReq(ownerHandoverReq));

    uhlc_root_port_model i_ports (.clk(clk), .reset_n(reset_n), .flipFrame(eng[8]), .touchPort(eng[9]),
        .frameCount(frameCount), .rootHubState(rootHubState), .rootPortState(rootPortState));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWrEn   <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge clk);
        regWrEn <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1;
        chk({what, " valid"}, 32'h1, {31'h0, regRdValid});
        chk(what, exp, regRdData);
    endtask

    // One-cycle pulse on the chosen engine or model lines
    task automatic pulse(input logic [9:0] m);
        @(posedge clk);
        eng <= m;
        @(posedge clk);
        eng <= '0;
        #1;
    endtask

    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        final_report();
    end

    initial begin
        reset_n = 1'b0;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 32'h0000_0000;
        isoDescSeen = 1'b0;
        eng = '0;
        mismatches = 0;
        compares = 0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        rd(8'h08, 32'h0000_0000, "cmd reset");
        rd(8'h0C, 32'h0000_0000, "evt reset");
        for (int i = 0; i < 6; i++) begin
            wr(ROWS[i][0][7:0], ROWS[i][1]);
            rd(ROWS[i][2][7:0], ROWS[i][3], "row");
        end
        $display("test table done");
        chk("ctrl go", 32'h1, {31'h0, ctrlListGo});
        pulse(10'h008);
        pulse(10'h010);
        chk("pend after heads", 32'h0, {30'h0, bulkPending, ctrlPending});
        pulse(10'h060);
        chk("engine pend", 32'h3, {30'h0, bulkPending, ctrlPending});
        for (int r = 0; r < 4; r++) begin
            wr(8'h04, 32'h0000_0030 | r);
            pulse(10'h004);
            for (int k = 0; k <= r; k++) begin
                chk("ctrl turn", 32'h0, {31'h0, pickBulk});
                pulse(10'h002);
            end
            chk("bulk turn", 32'h1, {31'h0, pickBulk});
        end
        wr(8'h04, 32'h0000_0020);
        chk("ctrl skip", 32'h0, {31'h0, ctrlListGo});
        chk("bulk go", 32'h1, {31'h0, bulkListGo});
        $display("test engine done");
        @(posedge clk);
        isoDescSeen <= 1'b1;
        wr(8'h04, 32'h0000_000C);
        pulse(10'h001);
        chk("periodic go", 32'h3, {30'h0, periodicFrameGo, isoDescServe});
        wr(8'h04, 32'h0000_0004);
        chk("iso skip", 32'h2, {30'h0, periodicFrameGo, isoDescServe});
        wr(8'h04, 32'h0000_0008);
        chk("held to frame", 32'h1, {31'h0, periodicFrameGo});
        pulse(10'h001);
        chk("periodic off", 32'h0, {30'h0, periodicFrameGo, isoDescServe});
        @(posedge clk);
        isoDescSeen <= 1'b0;
        $display("test periodic done");
        // Five overruns wrap the two-bit tally to one
        for (int t = 0; t < 5; t++) begin
            pulse(10'h080);
            rd(8'h0C, 32'h0000_0001, "overrun evt");
            wr(8'h0C, 32'h0000_0001);
        end
        rd(8'h08, 32'h0001_0006, "tally");
        pulse(10'h100);
        rd(8'h0C, 32'h0000_0020, "frame flip up");
        wr(8'h0C, 32'h0000_0020);
        pulse(10'h100);
        rd(8'h0C, 32'h0000_0020, "frame flip down");
        wr(8'h0C, 32'h0000_0020);
        pulse(10'h200);
        rd(8'h0C, 32'h0000_0040, "root change");
        wr(8'h0C, 32'h0000_0040);
        pulse(10'h200);
        rd(8'h0C, 32'h0000_0040, "root change again");
        wr(8'h0C, 32'h0000_0040);
        $display("test events done");
        wr(8'h08, 32'h0000_0008);
        rd(8'h0C, 32'h4000_0000, "handover evt");
        repeat (40) @(posedge clk);
        #1;
        chk("handover held", 32'h1, {31'h0, ownerHandoverReq});
        wr(8'h0C, 32'h4000_0000);
        chk("handover sw clear", 32'h0, {31'h0, ownerHandoverReq});
        $display("test handover done");
        wr(8'h04, 32'h0000_0030);
        wr(8'h08, 32'h0000_0001);
        chk("srst gate", 32'h0, {30'h0, bulkListGo, ctrlListGo});
        n = 0;
        while (softResetActive === 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
            #1;
        end
        chk("srst cycles", 32'd16, n);
        rd(8'h08, 32'h0000_0000, "srst self clear");
        $display("test soft reset done");
        wr(8'h08, 32'h0000_000E);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        rd(8'h08, 32'h0000_0000, "cmd rereset");
        rd(8'h0C, 32'h0000_0000, "evt rereset");
        chk("req rereset", 32'h0, {31'h0, ownerHandoverReq});
        $display("test reset done");
        final_report();
    end
endmodule // tb_top
